// ---- hw/dmc_pkg.sv ----
// Constants and types shared by the channel mode configuration block
package dmc_pkg;

   // ----------------------------------------------------------------
   // Bus and register geometry
   // ----------------------------------------------------------------
   localparam int unsigned DMC_ADDR_W = 20;
   localparam int unsigned DMC_DATA_W = 32;
   localparam int unsigned DMC_CHANS = 2;

   // Register indices; byte address is four times the index
   localparam logic [DMC_ADDR_W-1:0] DMC_MODE_A_IDX = 20'h0f00b;
   localparam logic [DMC_ADDR_W-1:0] DMC_MODE_B_IDX = 20'h0f01b;
   localparam logic [DMC_ADDR_W-1:0] DMC_STATUS_IDX = 20'h00000;
   localparam logic [DMC_ADDR_W-1:0] DMC_CH0_VIEW_IDX = 20'h00001;
   localparam logic [DMC_ADDR_W-1:0] DMC_CH1_VIEW_IDX = 20'h00002;
   localparam logic [DMC_ADDR_W-1:0] DMC_LAST_WR_IDX = 20'h00003;

   // ----------------------------------------------------------------
   // Field positions; bits 0 and 1 are shared by both mode registers
   // ----------------------------------------------------------------
   localparam int unsigned DMC_CS_BIT = 0;
   localparam int unsigned DMC_ZERO_BIT = 1;
   // First mode register
   localparam int unsigned DMC_DIR_LSB = 2;
   localparam int unsigned DMC_AUTOINIT_BIT = 4;
   localparam int unsigned DMC_TGT_DOWN_BIT = 5;
   localparam int unsigned DMC_MODE_LSB = 6;
   // Second mode register
   localparam int unsigned DMC_TGT_HOLD_BIT = 2;
   localparam int unsigned DMC_REQ_DOWN_BIT = 3;
   localparam int unsigned DMC_REQ_HOLD_BIT = 4;
   localparam int unsigned DMC_TGT_IO_BIT = 5;
   localparam int unsigned DMC_REQ_IO_BIT = 6;
   localparam int unsigned DMC_CYCLE_BIT = 7;
   // Status register
   localparam int unsigned DMC_ST_RSVD_DIR_BIT = 0;
   localparam int unsigned DMC_ST_ZERO_BIT = 1;

   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] DMC_MODE_RESET = 8'h00;
   localparam logic [1:0] DMC_STATUS_RESET = 2'h0;
   localparam logic [1:0] DMC_DIR_VERIFY = 2'h0;
   localparam logic [1:0] DMC_DIR_TO_TGT = 2'h1;
   localparam logic [1:0] DMC_DIR_TO_REQ = 2'h2;
   localparam logic [1:0] DMC_DIR_RSVD = 2'h3;

   // Data-transfer modes
   typedef enum logic [1:0] {
      DMC_XM_DEMAND = 2'h0,
      DMC_XM_SINGLE = 2'h1,
      DMC_XM_BLOCK = 2'h2,
      DMC_XM_CASCADE = 2'h3
   } dmc_xfer_mode_t;

   // Bus slave states, Gray coded
   typedef enum logic [1:0] {
      DMC_ST_IDLE = 2'b00,
      DMC_ST_WAIT = 2'b01,
      DMC_ST_ANS = 2'b11
   } dmc_bus_state_t;

endpackage

// ---- hw/dmc_chan_store.sv ----
// One channel's stored mode settings and their effective outputs
`timescale 1ns/1ps
module dmc_chan_store
   import dmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Committed writes aimed at this channel
   input wire logic wr_a,
   input wire logic wr_b,
   input wire logic [7:0] wdata,
   // Stored images for readback, select and must-be-zero bits cleared
   output logic [7:0] image_a,
   output logic [7:0] image_b,
   // Effective settings
   output logic autoinit_enable,
   output logic [1:0] transfer_direction,
   output logic [1:0] transfer_mode_sel,
   output logic cycle_option_sel,
   output logic requester_space_io,
   output logic target_space_io,
   output logic requester_addr_hold,
   output logic requester_addr_down,
   output logic target_addr_hold,
   output logic target_addr_down,
   output logic requester_byte_split,
   output logic target_byte_split
);

   logic [7:0] mode_a;
   logic [7:0] mode_b;
   logic cascade;
   logic eff_req_down;
   logic eff_tgt_down;

   // RL17: this copy changes only on its own channel's write
   // RL18: reset clears every setting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_a <= DMC_MODE_RESET;
         mode_b <= DMC_MODE_RESET;
      end else begin
         if (wr_a) begin
            mode_a <= wdata;
         end
         if (wr_b) begin
            mode_b <= wdata;
         end
      end
   end

   // Images carry zero in the select and must-be-zero positions
   assign image_a = {mode_a[7:2], 2'b00};
   assign image_b = {mode_b[7:2], 2'b00};

   // RL16: cascade mode decode
   assign cascade = (mode_a[DMC_MODE_LSB +: 2] == DMC_XM_CASCADE);
   // RL13: hold overrides the requester step direction
   assign eff_req_down = mode_b[DMC_REQ_DOWN_BIT] & ~mode_b[DMC_REQ_HOLD_BIT];
   // RL14: hold overrides the target step direction
   assign eff_tgt_down = mode_a[DMC_TGT_DOWN_BIT] & ~mode_b[DMC_TGT_HOLD_BIT];

   // Effective outputs are registered so consumers see clean levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         autoinit_enable <= 1'b0;
         transfer_direction <= DMC_DIR_VERIFY;
         transfer_mode_sel <= DMC_XM_DEMAND;
         cycle_option_sel <= 1'b0;
         requester_space_io <= 1'b0;
         target_space_io <= 1'b0;
         requester_addr_hold <= 1'b0;
         requester_addr_down <= 1'b0;
         target_addr_hold <= 1'b0;
         target_addr_down <= 1'b0;
         requester_byte_split <= 1'b0;
         target_byte_split <= 1'b0;
      end else begin
         // RL1: autoinitialize enable
         autoinit_enable <= mode_a[DMC_AUTOINIT_BIT];
         // RL2: direction, RL3: forced to verify in cascade
         transfer_direction <= cascade ? DMC_DIR_VERIFY : mode_a[DMC_DIR_LSB +: 2];
         transfer_mode_sel <= mode_a[DMC_MODE_LSB +: 2];
         // RL6: bus cycle option
         cycle_option_sel <= mode_b[DMC_CYCLE_BIT];
         // RL7: requester space, RL8: ignored in fly-by
         requester_space_io <= mode_b[DMC_REQ_IO_BIT] & mode_b[DMC_CYCLE_BIT];
         // RL9: target space
         target_space_io <= mode_b[DMC_TGT_IO_BIT];
         // RL10: requester hold
         requester_addr_hold <= mode_b[DMC_REQ_HOLD_BIT];
         // RL11: requester step direction
         requester_addr_down <= eff_req_down;
         target_addr_hold <= mode_b[DMC_TGT_HOLD_BIT];
         // RL15: target step direction
         target_addr_down <= eff_tgt_down;
         // RL12: decrementing splits words into bytes
         requester_byte_split <= eff_req_down;
         target_byte_split <= eff_tgt_down;
      end
   end

endmodule

// ---- hw/dmc_mode_cfg.sv ----
// Two-channel DMA mode configuration registers behind an APB slave
//
// Summary of operation
// RL1: Autoinitialize bit of selected channel: 0 disables, 1 enables.
// RL2: Direction 00 verify, 01 requester to target, 10 target to requester.
// RL3: In cascade mode the channel's direction setting is ignored.
// RL4: Software writes zero to bit 1 of both mode registers.
// RL5: Bit 0 of a mode write picks channel 0 or 1 for bits 7-2.
// RL6: Second register bit 7: 0 fly-by, 1 two-cycle transfers.
// RL7: Second register bit 6: requester in memory (0) or I/O (1).
// RL8: Requester space is disregarded while fly-by is selected.
// RL9: Second register bit 5: target in memory (0) or I/O (1).
// RL10: Second register bit 4 holds requester address; 0 lets it step.
// RL11: Second register bit 3: requester increments (0) or decrements (1).
// RL12: A decrementing address turns each word into two byte transfers.
// RL13: Requester step direction is ignored while requester hold is 1.
// RL14: Second register bit 2 holds target address; 0 lets it step.
// RL15: First register bit 5: target increments (0) or decrements (1).
// RL16: First register bits 7-6: demand, single, block, cascade (11).
// RL17: Each channel keeps its own copy; writes touch only the chosen one.
// RL18: Reset clears all settings of both channels.
`timescale 1ns/1ps
module dmc_mode_cfg
   import dmc_pkg::*;
#(
   parameter int unsigned CHANS = dmc_pkg::DMC_CHANS
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RSTN,
   // APB request
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [dmc_pkg::DMC_ADDR_W-1:0] PADDR,
   input wire logic [dmc_pkg::DMC_DATA_W-1:0] PWDATA,
   input wire logic [3:0] PSTRB,
   // APB answer
   output logic PREADY,
   output logic [dmc_pkg::DMC_DATA_W-1:0] PRDATA,
   output logic PSLVERR,
   // Transfer mode per channel
   output logic [CHANS-1:0] AUTOINIT_ENABLE,
   output logic [2*CHANS-1:0] TRANSFER_DIRECTION,
   output logic [2*CHANS-1:0] TRANSFER_MODE_SEL,
   // Bus cycle and device space per channel
   output logic [CHANS-1:0] CYCLE_OPTION_SEL,
   output logic [CHANS-1:0] REQUESTER_SPACE_IO,
   output logic [CHANS-1:0] TARGET_SPACE_IO,
   // Address stepping per channel
   output logic [CHANS-1:0] REQUESTER_ADDR_HOLD,
   output logic [CHANS-1:0] REQUESTER_ADDR_DOWN,
   output logic [CHANS-1:0] TARGET_ADDR_HOLD,
   output logic [CHANS-1:0] TARGET_ADDR_DOWN,
   output logic [CHANS-1:0] REQUESTER_BYTE_SPLIT,
   output logic [CHANS-1:0] TARGET_BYTE_SPLIT
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   dmc_bus_state_t state;
   dmc_bus_state_t next_state;
   logic [DMC_ADDR_W-1:0] word_idx;
   logic access;
   logic commit;
   logic wr_commit;
   logic aligned;
   logic hit_mode_a;
   logic hit_mode_b;
   logic hit_status;
   logic hit_ch0_view;
   logic hit_ch1_view;
   logic hit_last_wr;
   logic hit_any;
   logic hit_read_only;
   logic low_lane;
   logic mode_wr;
   logic wr_mode_a;
   logic wr_mode_b;
   logic wr_status;
   logic [7:0] wbyte;
   logic chan_sel;
   logic set_rsvd_dir;
   logic set_zero_bit;
   logic [1:0] status;
   logic [1:0] next_status;
   logic [9:0] last_wr;
   logic [7:0] image_a [CHANS];
   logic [7:0] image_b [CHANS];
   logic [DMC_DATA_W-1:0] rd_word;
   logic next_pready;
   logic next_pslverr;
   logic [DMC_DATA_W-1:0] next_prdata;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   // Word index; the two low address bits only test alignment
   assign word_idx = {2'b00, PADDR[DMC_ADDR_W-1:2]};
   assign aligned = (PADDR[1:0] == 2'b00);
   assign hit_mode_a = aligned && (word_idx == DMC_MODE_A_IDX);
   assign hit_mode_b = aligned && (word_idx == DMC_MODE_B_IDX);
   assign hit_status = aligned && (word_idx == DMC_STATUS_IDX);
   assign hit_ch0_view = aligned && (word_idx == DMC_CH0_VIEW_IDX);
   assign hit_ch1_view = aligned && (word_idx == DMC_CH1_VIEW_IDX);
   assign hit_last_wr = aligned && (word_idx == DMC_LAST_WR_IDX);
   assign hit_any = hit_mode_a | hit_mode_b | hit_status
                  | hit_ch0_view | hit_ch1_view | hit_last_wr;
   // Views are read only; a write there is answered with an error
   assign hit_read_only = hit_ch0_view | hit_ch1_view | hit_last_wr;

   // ----------------------------------------------------------------
   // Bus slave sequencing
   // ----------------------------------------------------------------

   // Access phase seen by the slave
   assign access = PSEL & PENABLE;
   // A transfer completes at the edge where pready is sampled high
   assign commit = access & PREADY;
   assign wr_commit = commit & PWRITE & ~PSLVERR;

   // Two wait states give the decode a full cycle and keep pready a flop
   always_comb begin
      next_state = state;
      case (state)
         DMC_ST_IDLE: begin
            if (access) begin
               next_state = DMC_ST_WAIT;
            end
         end
         DMC_ST_WAIT: begin
            next_state = DMC_ST_ANS;
         end
         DMC_ST_ANS: begin
            next_state = DMC_ST_IDLE;
         end
         default: begin
            next_state = DMC_ST_IDLE;
         end
      endcase
   end

   // Answer is prepared during the wait state, held for one cycle
   assign next_pready = (state == DMC_ST_WAIT);
   assign next_pslverr = (state == DMC_ST_WAIT)
                       && (!hit_any || (PWRITE && hit_read_only));
   assign next_prdata = ((state == DMC_ST_WAIT) && !PWRITE) ? rd_word : '0;

   // Bus slave flops
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         state <= DMC_ST_IDLE;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= '0;
      end else begin
         state <= next_state;
         PREADY <= next_pready;
         PSLVERR <= next_pslverr;
         PRDATA <= next_prdata;
      end
   end

   // ----------------------------------------------------------------
   // Mode register writes
   // ----------------------------------------------------------------

   // Only the low byte lane carries register data
   assign low_lane = PSTRB[0];
   assign wbyte = PWDATA[7:0];
   assign mode_wr = wr_commit & low_lane;
   assign wr_mode_a = mode_wr & hit_mode_a;
   assign wr_mode_b = mode_wr & hit_mode_b;
   assign wr_status = wr_commit & low_lane & hit_status;

   // RL5: bit 0 of the written byte names the channel
   assign chan_sel = wbyte[DMC_CS_BIT];

   // RL17: one store per channel, each enabled by its select match
   for (genvar ch = 0; ch < CHANS; ch++) begin : g_chan
      logic sel_me;
      assign sel_me = (chan_sel == 1'(ch));
      dmc_chan_store u_store (
         .clk(MCLK),
         .rst_n(RSTN),
         .wr_a(wr_mode_a & sel_me),
         .wr_b(wr_mode_b & sel_me),
         .wdata(wbyte),
         .image_a(image_a[ch]),
         .image_b(image_b[ch]),
         .autoinit_enable(AUTOINIT_ENABLE[ch]),
         .transfer_direction(TRANSFER_DIRECTION[2*ch +: 2]),
         .transfer_mode_sel(TRANSFER_MODE_SEL[2*ch +: 2]),
         .cycle_option_sel(CYCLE_OPTION_SEL[ch]),
         .requester_space_io(REQUESTER_SPACE_IO[ch]),
         .target_space_io(TARGET_SPACE_IO[ch]),
         .requester_addr_hold(REQUESTER_ADDR_HOLD[ch]),
         .requester_addr_down(REQUESTER_ADDR_DOWN[ch]),
         .target_addr_hold(TARGET_ADDR_HOLD[ch]),
         .target_addr_down(TARGET_ADDR_DOWN[ch]),
         .requester_byte_split(REQUESTER_BYTE_SPLIT[ch]),
         .target_byte_split(TARGET_BYTE_SPLIT[ch])
      );
   end

   // ----------------------------------------------------------------
   // Programming error status
   // ----------------------------------------------------------------

   // RL2: a reserved direction code is stored but flagged
   assign set_rsvd_dir = wr_mode_a && (wbyte[DMC_DIR_LSB +: 2] == DMC_DIR_RSVD);
   // RL4: software owes a zero in bit 1; a one is flagged, not refused
   assign set_zero_bit = (wr_mode_a | wr_mode_b) && wbyte[DMC_ZERO_BIT];

   // Write one to clear; a new error in the same cycle wins
   always_comb begin
      next_status = status;
      if (wr_status) begin
         next_status = status & ~wbyte[1:0];
      end
      if (set_rsvd_dir) begin
         next_status[DMC_ST_RSVD_DIR_BIT] = 1'b1;
      end
      if (set_zero_bit) begin
         next_status[DMC_ST_ZERO_BIT] = 1'b1;
      end
   end

   // Status and last-write capture
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         status <= DMC_STATUS_RESET;
         last_wr <= '0;
      end else begin
         status <= next_status;
         if (wr_mode_a | wr_mode_b) begin
            last_wr <= {wr_mode_b, 1'b1, wbyte};
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data selection
   // ----------------------------------------------------------------

   // Mode registers are write only and read as zero
   assign rd_word = hit_status ? {30'h0, status} :
                    hit_ch0_view ? {16'h0, image_b[0], image_a[0]} :
                    hit_ch1_view ? {16'h0, image_b[CHANS-1], image_a[CHANS-1]} :
                    hit_last_wr ? {22'h0, last_wr} :
                    32'h0;

endmodule

// ---- tb/dmc_mode_cfg_asserts.sv ----
// Port-level checks for the channel mode configuration block
`timescale 1ns/1ps
module dmc_mode_cfg_asserts
   import dmc_pkg::*;
#(
   parameter int unsigned CHANS = 2
) (
   // Clock, reset and bus
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic PREADY,
   input wire logic [dmc_pkg::DMC_DATA_W-1:0] PRDATA,
   // Channel settings
   input wire logic [CHANS-1:0] AUTOINIT_ENABLE,
   input wire logic [2*CHANS-1:0] TRANSFER_DIRECTION,
   input wire logic [2*CHANS-1:0] TRANSFER_MODE_SEL,
   input wire logic [CHANS-1:0] CYCLE_OPTION_SEL,
   input wire logic [CHANS-1:0] REQUESTER_SPACE_IO,
   input wire logic [CHANS-1:0] TARGET_SPACE_IO,
   input wire logic [CHANS-1:0] REQUESTER_ADDR_HOLD,
   input wire logic [CHANS-1:0] REQUESTER_ADDR_DOWN,
   input wire logic [CHANS-1:0] TARGET_ADDR_HOLD,
   input wire logic [CHANS-1:0] TARGET_ADDR_DOWN,
   input wire logic [CHANS-1:0] REQUESTER_BYTE_SPLIT,
   input wire logic [CHANS-1:0] TARGET_BYTE_SPLIT
);
   logic [CHANS-1:0] casc_bad;
   logic [14*CHANS-1:0] settings;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   // Direction shown while cascade is chosen, per channel
   always_comb begin
      for (int c = 0; c < CHANS; c++)
         casc_bad[c] = (TRANSFER_MODE_SEL[2*c+:2] == 2'h3)
            && (TRANSFER_DIRECTION[2*c+:2] != 2'h0);
   end
   // All settings in one word, so any change is seen
   assign settings = {AUTOINIT_ENABLE, TRANSFER_DIRECTION, TRANSFER_MODE_SEL, CYCLE_OPTION_SEL,
      REQUESTER_SPACE_IO, TARGET_SPACE_IO, REQUESTER_ADDR_HOLD, REQUESTER_ADDR_DOWN,
      TARGET_ADDR_HOLD, TARGET_ADDR_DOWN, REQUESTER_BYTE_SPLIT, TARGET_BYTE_SPLIT};
   property p_cascade;
      casc_bad == '0;
   endproperty
   a_cascade: assert property (p_cascade) else $error("direction shown in cascade");
   property p_reset_clear;
      $rose(RSTN) |-> settings == '0;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("settings not cleared");
   property p_change_cause;
      $changed(settings) |-> $past(PREADY && PWRITE, 1) || $past(PREADY && PWRITE, 2);
   endproperty
   a_change_cause: assert property (p_change_cause) else $error("setting changed unbidden");
   property p_req_space;
      (REQUESTER_SPACE_IO & ~CYCLE_OPTION_SEL) == '0;
   endproperty
   a_req_space: assert property (p_req_space) else $error("requester space in fly-by");
   property p_req_hold;
      (REQUESTER_ADDR_DOWN & REQUESTER_ADDR_HOLD) == '0;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("requester steps while held");
   property p_tgt_hold;
      (TARGET_ADDR_DOWN & TARGET_ADDR_HOLD) == '0;
   endproperty
   a_tgt_hold: assert property (p_tgt_hold) else $error("target steps while held");
   property p_split;
      REQUESTER_BYTE_SPLIT == REQUESTER_ADDR_DOWN && TARGET_BYTE_SPLIT == TARGET_ADDR_DOWN;
   endproperty
   a_split: assert property (p_split) else $error("byte split off decrement");
   property p_ready_time;
      $rose(PSEL && PENABLE) |-> !PREADY ##1 !PREADY ##1 PREADY;
   endproperty
   a_ready_time: assert property (p_ready_time) else $error("answer not after two waits");
   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
   property p_rdata_idle;
      !PREADY |-> PRDATA == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
endmodule
bind dmc_mode_cfg dmc_mode_cfg_asserts #(.CHANS(CHANS)) chk_u (.MCLK(MCLK), .RSTN(RSTN),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PRDATA(PRDATA),
   .AUTOINIT_ENABLE(AUTOINIT_ENABLE), .TRANSFER_DIRECTION(TRANSFER_DIRECTION),
   .TRANSFER_MODE_SEL(TRANSFER_MODE_SEL), .CYCLE_OPTION_SEL(CYCLE_OPTION_SEL),
   .REQUESTER_SPACE_IO(REQUESTER_SPACE_IO), .TARGET_SPACE_IO(TARGET_SPACE_IO),
   .REQUESTER_ADDR_HOLD(REQUESTER_ADDR_HOLD), .REQUESTER_ADDR_DOWN(REQUESTER_ADDR_DOWN),
   .TARGET_ADDR_HOLD(TARGET_ADDR_HOLD), .TARGET_ADDR_DOWN(TARGET_ADDR_DOWN),
   .REQUESTER_BYTE_SPLIT(REQUESTER_BYTE_SPLIT), .TARGET_BYTE_SPLIT(TARGET_BYTE_SPLIT));

// ---- tb/dmc_req_model.sv ----
// Requester-side address sequencer that follows one channel's settings
`timescale 1ns/1ps
module dmc_req_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Settings and one word transfer per step
   input wire logic hold,
   input wire logic down,
   input wire logic split,
   input wire logic step,
   // Current requester address
   output logic [15:0] addr
);
   // hold wins; a falling word goes as two bytes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         addr <= 16'h1000;
      else if (step && !hold)
         addr <= down ? addr - (split ? 16'h0002 : 16'h0001) : addr + 16'h0002;
   end
endmodule

// ---- tb/dmc_mode_cfg_tb.sv ----
// Self-checking bench for the channel mode configuration block
`timescale 1ns/1ps
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH %0t %s", $time, m); end end
module dmc_mode_cfg_tb;
   import dmc_pkg::*;
   localparam logic [19:0] A_ADDR = {DMC_MODE_A_IDX[17:0], 2'b00};
   localparam logic [19:0] B_ADDR = {DMC_MODE_B_IDX[17:0], 2'b00};
   logic MCLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, step, er;
   logic [19:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [3:0] PSTRB, TRANSFER_DIRECTION, TRANSFER_MODE_SEL;
   logic [1:0] AUTOINIT_ENABLE, CYCLE_OPTION_SEL, REQUESTER_SPACE_IO, TARGET_SPACE_IO;
   logic [1:0] REQUESTER_ADDR_HOLD, REQUESTER_ADDR_DOWN, TARGET_ADDR_HOLD, TARGET_ADDR_DOWN;
   logic [1:0] REQUESTER_BYTE_SPLIT, TARGET_BYTE_SPLIT;
   logic [15:0] raddr;
   logic [7:0] sha [2];
   logic [7:0] shb [2];
   int err_count, comparisons;
   dmc_mode_cfg #(.CHANS(2)) dut_u (.MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
      .PRDATA(PRDATA), .PSLVERR(PSLVERR), .AUTOINIT_ENABLE(AUTOINIT_ENABLE),
      .TRANSFER_DIRECTION(TRANSFER_DIRECTION), .TRANSFER_MODE_SEL(TRANSFER_MODE_SEL),
      .CYCLE_OPTION_SEL(CYCLE_OPTION_SEL), .REQUESTER_SPACE_IO(REQUESTER_SPACE_IO),
      .TARGET_SPACE_IO(TARGET_SPACE_IO), .REQUESTER_ADDR_HOLD(REQUESTER_ADDR_HOLD),
      .REQUESTER_ADDR_DOWN(REQUESTER_ADDR_DOWN), .TARGET_ADDR_HOLD(TARGET_ADDR_HOLD),
      .TARGET_ADDR_DOWN(TARGET_ADDR_DOWN), .REQUESTER_BYTE_SPLIT(REQUESTER_BYTE_SPLIT),
      .TARGET_BYTE_SPLIT(TARGET_BYTE_SPLIT));
   dmc_req_model req_u (.clk(MCLK), .rst_n(RSTN), .hold(REQUESTER_ADDR_HOLD[0]),
      .down(REQUESTER_ADDR_DOWN[0]), .split(REQUESTER_BYTE_SPLIT[0]), .step(step),
      .addr(raddr));
   // Free-running system clock
   initial begin
      MCLK = 1'b0;
      forever #2.5 MCLK = ~MCLK;
   end
   // Bus cycle held until ready is sampled; the lead edge keeps drives apart
   task automatic apb(input logic w, input logic [19:0] a, input logic [7:0] d,
         input logic [3:0] s);
      int n;
      n = 0;
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {24'h000000, d};
      PSTRB <= s;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      `CHK(n < 20, 1'b1, "no ready")
   endtask
   // Compare both channels with the shadow copies
   task automatic chk_all();
      logic [7:0] a, b;
      for (int c = 0; c < 2; c++) begin
         a = sha[c];
         b = shb[c];
         `CHK(AUTOINIT_ENABLE[c], a[4], "autoinit")
         `CHK(TRANSFER_MODE_SEL[2*c+:2], a[7:6], "mode")
         `CHK(TRANSFER_DIRECTION[2*c+:2], (&a[7:6]) ? 2'h0 : a[3:2], "dir")
         `CHK(TARGET_ADDR_DOWN[c], a[5] & ~b[2], "tgt down")
         `CHK(TARGET_ADDR_HOLD[c], b[2], "tgt hold")
         `CHK(CYCLE_OPTION_SEL[c], b[7], "cycle")
         `CHK(REQUESTER_SPACE_IO[c], b[6] & b[7], "req io")
         `CHK(TARGET_SPACE_IO[c], b[5], "tgt io")
         `CHK(REQUESTER_ADDR_HOLD[c], b[4], "req hold")
         `CHK(REQUESTER_ADDR_DOWN[c], b[3] & ~b[4], "req down")
         `CHK(REQUESTER_BYTE_SPLIT[c], b[3] & ~b[4], "req split")
         `CHK(TARGET_BYTE_SPLIT[c], a[5] & ~b[2], "tgt split")
      end
   endtask
   // Mode write; only the chosen channel's shadow follows
   task automatic wr(input logic b, input logic [7:0] d);
      apb(1'b1, b ? B_ADDR : A_ADDR, d, 4'hf);
      if (b)
         shb[d[0]] = d;
      else
         sha[d[0]] = d;
      repeat (2) @(posedge MCLK);
      #1;
      chk_all();
   endtask
   task automatic t_reset();
      chk_all();
      apb(1'b0, A_ADDR, 8'h00, 4'hf);
      `CHK({er, rd}, 33'h0, "mode read")
   endtask
   // Every mode and direction, alternating channels; bit 1 kept clear
   task automatic t_mode_a();
      logic [1:0] m;
      for (int i = 0; i < 8; i++) begin
         m = i[2:1];
         wr(1'b0, {m, i[0] ^ m[0], ~m[0], (m == 2'h3) ? 2'h1 : m, 1'b0, i[0]});
      end
   endtask
   task automatic t_mode_b();
      logic [7:0] tbl [6] = '{8'hc8, 8'h40, 8'h18, 8'h24, 8'h08, 8'hfc};
      for (int i = 0; i < 12; i++)
         wr(1'b1, {tbl[(i / 2 + 3 * i[0]) % 6][7:1], i[0]});
   endtask
   // Requester address walks four words under up, hold and down
   task automatic t_req_walk();
      logic [7:0] v [3] = '{8'h00, 8'h18, 8'h08};
      logic [15:0] s;
      for (int k = 0; k < 3; k++) begin
         wr(1'b1, v[k]);
         s = raddr;
         @(posedge MCLK);
         step <= 1'b1;
         repeat (4) @(posedge MCLK);
         step <= 1'b0;
         #1;
         `CHK(raddr - s, (k == 0) ? 16'h0008 : (k == 1) ? 16'h0000 : 16'hfff8, "walk")
      end
   endtask
   // Unmapped, view write and no-strobe write store nothing
   task automatic t_bus();
      apb(1'b1, 20'h00100, 8'h00, 4'hf);
      `CHK(er, 1'b1, "unmapped")
      apb(1'b1, 20'h00004, 8'hff, 4'hf);
      `CHK(er, 1'b1, "view write")
      apb(1'b1, A_ADDR, 8'hf1, 4'h0);
      repeat (2) @(posedge MCLK);
      #1;
      chk_all();
      // Views show each channel's stored bytes with bits 1-0 read as zero
      for (int c = 0; c < 2; c++) begin
         apb(1'b0, 20'h00004 << c, 8'h00, 4'hf);
         `CHK({er, rd}, {17'h0, shb[c][7:2], 2'b00, sha[c][7:2], 2'b00}, "view")
      end
      apb(1'b0, 20'h00000, 8'h00, 4'hf);
      `CHK({er, rd}, 33'h0, "status")
   endtask
   // Reset in mid-run clears both channels
   task automatic t_rereset();
      @(posedge MCLK);
      RSTN <= 1'b0;
      repeat (3) @(posedge MCLK);
      #1;
      sha = '{8'h00, 8'h00};
      shb = '{8'h00, 8'h00};
      chk_all();
      @(posedge MCLK);
      RSTN <= 1'b1;
      @(posedge MCLK);
      #1;
      chk_all();
      wr(1'b0, 8'h91);
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial begin
      #20000;
      err_count++;
      conclude();
   end
   // Main sequence
   initial begin
      {RSTN, PSEL, PENABLE, PWRITE, step} = 5'h00;
      PADDR = 20'h00000;
      PWDATA = 32'h00000000;
      PSTRB = 4'h0;
      err_count = 0;
      comparisons = 0;
      sha = '{8'h00, 8'h00};
      shb = '{8'h00, 8'h00};
      repeat (12) @(posedge MCLK);
      RSTN <= 1'b1;
      @(posedge MCLK);
      t_reset();
      t_mode_a();
      t_mode_b();
      t_req_walk();
      t_bus();
      t_rereset();
      conclude();
   end
endmodule
